//--- hdl/regfile_pkg.sv
// Contract
// - Two identical banks of byte registers exist: main and alternate.
// - Each bank holds accumulator, flags and six general bytes, each addressable.
// - Contents move between banks only through the exchange commands.
// - The accumulator supplies an operand and takes the written-back result.
// - Pair one reads and writes as two bytes or one 16-bit word.
// - Pair two reads and writes as two bytes or one 16-bit word.
// - Pair three reads and writes as two bytes or one 16-bit word.
// - In a word, the first-named byte is bits 15:8, second bits 7:0. For PAIR_AF the code puts flags in bits 15:8 and the accumulator in 7:0.
package regfile_pkg;

  // ****************************************************************
  // Byte register indices within one bank.
  // ****************************************************************
  localparam logic [2:0] IDX_PAIR1_HI = 3'h0;
  localparam logic [2:0] IDX_PAIR1_LO = 3'h1;
  localparam logic [2:0] IDX_PAIR2_HI = 3'h2;
  localparam logic [2:0] IDX_PAIR2_LO = 3'h3;
  localparam logic [2:0] IDX_PAIR3_UP = 3'h4;
  localparam logic [2:0] IDX_PAIR3_DN = 3'h5;
  localparam logic [2:0] IDX_FLAGS = 3'h6;
  localparam logic [2:0] IDX_ACC = 3'h7;

  // ****************************************************************
  // Word pair indices.
  // ****************************************************************
  localparam logic [1:0] PAIR_1 = 2'h0;
  localparam logic [1:0] PAIR_2 = 2'h1;
  localparam logic [1:0] PAIR_3 = 2'h2;
  localparam logic [1:0] PAIR_AF = 2'h3;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic BANK_MAIN = 1'b0;

  // ****************************************************************
  // Exchange commands.
  // ****************************************************************
  typedef enum logic [1:0] {
    XCH_NONE = 2'b00,
    XCH_ACCFLAGS = 2'b01,
    XCH_PAIRS = 2'b10
  } xch_e;

endpackage

//--- hdl/reg_bank.sv
module reg_bank
  import regfile_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] wr_en_i,
  input wire logic [63:0] wr_data_i,
  output logic [63:0] rd_data_o
);

  // ****************************************************************
  // Eight byte registers, each with its own write enable.
  // ****************************************************************
  logic [7:0] bytes [8];

  for (genvar g = 0; g < 8; g++) begin : g_byte
    always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
        bytes[g] <= BYTE_RESET;
      end else if (wr_en_i[g]) begin
        bytes[g] <= wr_data_i[8*g +: 8];
      end
    end
    assign rd_data_o[8*g +: 8] = bytes[g];
  end

endmodule // reg_bank

//--- hdl/dual_bank_regfile.sv
module dual_bank_regfile
  import regfile_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] rd_a_sel_i,
  output logic [7:0] rd_a_data_o,
  input wire logic [2:0] rd_b_sel_i,
  output logic [7:0] rd_b_data_o,
  input wire logic [1:0] rd_pair_sel_i,
  output logic [15:0] rd_pair_data_o,
  output logic [7:0] acc_o,
  output logic [7:0] flags_o,
  input wire logic wr_byte_en_i,
  input wire logic [2:0] wr_byte_sel_i,
  input wire logic [7:0] wr_byte_data_i,
  input wire logic wr_pair_en_i,
  input wire logic [1:0] wr_pair_sel_i,
  input wire logic [15:0] wr_pair_data_i,
  input wire logic acc_wr_en_i,
  input wire logic [7:0] acc_result_i,
  input wire logic flags_wr_en_i,
  input wire logic [7:0] flags_result_i,
  input wire logic [1:0] xch_i,
  output logic acc_bank_o,
  output logic pair_bank_o
);

  // ****************************************************************
  // Bank-select state: one bit for accumulator and flags, one for pairs.
  // ****************************************************************
  logic acc_bank;
  logic pair_bank;
  xch_e xch_cmd;
  assign xch_cmd = xch_e'(xch_i);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      acc_bank <= BANK_MAIN;
      pair_bank <= BANK_MAIN;
    end else begin
      // Only the exchange commands flip a bank; loads never do.
      if (xch_cmd == XCH_ACCFLAGS) begin
        acc_bank <= ~acc_bank;
      end
      if (xch_cmd == XCH_PAIRS) begin
        pair_bank <= ~pair_bank;
      end
    end
  end

  assign acc_bank_o = acc_bank;
  assign pair_bank_o = pair_bank;

  // ****************************************************************
  // Per-byte write enables and data in the logical view.
  // Priority: accumulator/flag results, then pair write, then byte write,
  // so an operation result is never lost to a word write of the same byte.
  // ****************************************************************
  logic [7:0] byte_hit;
  logic [7:0] pair_hit;
  logic [7:0] log_we;
  logic [63:0] log_wd;
  logic [2:0] pw_hi;

  assign pw_hi = {wr_pair_sel_i, 1'b0};
  assign byte_hit = wr_byte_en_i ? (8'h01 << wr_byte_sel_i) : 8'h00;
  assign pair_hit = wr_pair_en_i ? (8'h03 << pw_hi) : 8'h00;

  always_comb begin
    log_we = byte_hit | pair_hit;
    log_wd = {8{wr_byte_data_i}};
    if (wr_pair_en_i) begin
      // Lower-indexed byte is the high byte of the word; for PAIR_AF that is the flags byte.
      log_wd[8*pw_hi +: 8] = wr_pair_data_i[15:8];
      log_wd[8*(pw_hi + 3'h1) +: 8] = wr_pair_data_i[7:0];
    end
    if (acc_wr_en_i) begin
      log_we[IDX_ACC] = 1'b1;
      log_wd[8*IDX_ACC +: 8] = acc_result_i;
    end
    if (flags_wr_en_i) begin
      log_we[IDX_FLAGS] = 1'b1;
      log_wd[8*IDX_FLAGS +: 8] = flags_result_i;
    end
  end

  // ****************************************************************
  // Two physical banks; bank select routes enables.
  // ****************************************************************
  logic [7:0] sel_alt;
  logic [7:0] we_main;
  logic [7:0] we_alt;
  logic [63:0] q_main;
  logic [63:0] q_alt;
  logic [63:0] q_view;

  assign sel_alt = {{2{acc_bank}}, {6{pair_bank}}};
  assign we_main = log_we & ~sel_alt;
  assign we_alt = log_we & sel_alt;

  reg_bank u_main (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(we_main),
    .wr_data_i(log_wd),
    .rd_data_o(q_main)
  );

  reg_bank u_alt (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(we_alt),
    .wr_data_i(log_wd),
    .rd_data_o(q_alt)
  );

  for (genvar g = 0; g < 8; g++) begin : g_view
    assign q_view[8*g +: 8] = sel_alt[g] ? q_alt[8*g +: 8] :
                                           q_main[8*g +: 8];
  end

  // ****************************************************************
  // Read ports.
  // ****************************************************************
  logic [2:0] pr_hi;
  assign pr_hi = {rd_pair_sel_i, 1'b0};
  assign rd_a_data_o = q_view[8*rd_a_sel_i +: 8];
  assign rd_b_data_o = q_view[8*rd_b_sel_i +: 8];
  assign rd_pair_data_o = {q_view[8*pr_hi +: 8],
                           q_view[8*(pr_hi + 3'h1) +: 8]};
  assign acc_o = q_view[8*IDX_ACC +: 8];
  assign flags_o = q_view[8*IDX_FLAGS +: 8];

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_acc_result;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      acc_wr_en_i && xch_cmd != XCH_ACCFLAGS |=> acc_o == $past(acc_result_i);
  endproperty
  a_acc_result: assert property (p_acc_result)
    else $error("accumulator did not take the result");

  property p_pair_word;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_pair_en_i && !acc_wr_en_i && !flags_wr_en_i && xch_i == 2'b00 &&
      rd_pair_sel_i == wr_pair_sel_i
      |=> rd_pair_data_o == $past(wr_pair_data_i);
  endproperty
  a_pair_word: assert property (p_pair_word)
    else $error("pair word did not read back");

  property p_pair_bytes;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      rd_a_sel_i == {rd_pair_sel_i, 1'b0} &&
      rd_b_sel_i == {rd_pair_sel_i, 1'b1}
      |-> rd_pair_data_o == {rd_a_data_o, rd_b_data_o};
  endproperty
  a_pair_bytes: assert property (p_pair_bytes)
    else $error("pair byte order wrong");

  property p_xch_one_cycle;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      xch_cmd == XCH_PAIRS |=> pair_bank != $past(pair_bank) &&
                               acc_bank == $past(acc_bank);
  endproperty
  a_xch_one_cycle: assert property (p_xch_one_cycle)
    else $error("pair exchange failed");

  property p_xch_acc;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      xch_cmd == XCH_ACCFLAGS |=> acc_bank != $past(acc_bank) &&
                                  pair_bank == $past(pair_bank);
  endproperty
  a_xch_acc: assert property (p_xch_acc)
    else $error("accumulator exchange failed");

  property p_no_xch_stable;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      xch_cmd == XCH_NONE |=> $stable(acc_bank) && $stable(pair_bank);
  endproperty
  a_no_xch_stable: assert property (p_no_xch_stable)
    else $error("bank changed without exchange");

  property p_xch_ignored;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      xch_i == 2'h3 |=> $stable(acc_bank) && $stable(pair_bank);
  endproperty
  a_xch_ignored: assert property (p_xch_ignored)
    else $error("reserved exchange code changed a bank");

  property p_flags_result;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      flags_wr_en_i && xch_cmd != XCH_ACCFLAGS
      |=> flags_o == $past(flags_result_i);
  endproperty
  a_flags_result: assert property (p_flags_result)
    else $error("flag register did not take the result");

  property p_alt_untouched;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      pair_bank == BANK_MAIN && xch_cmd == XCH_NONE
      |=> q_alt[47:0] == $past(q_alt[47:0]);
  endproperty
  a_alt_untouched: assert property (p_alt_untouched)
    else $error("alternate pairs written while main selected");

  property p_byte_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_byte_en_i && !wr_pair_en_i && wr_byte_sel_i < IDX_FLAGS &&
      xch_i == 2'b00 && rd_a_sel_i == wr_byte_sel_i
      ##1 rd_a_sel_i == $past(rd_a_sel_i)
      |-> rd_a_data_o == $past(wr_byte_data_i);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write did not read back");

  c_xch_pairs: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    xch_cmd == XCH_PAIRS ##1 wr_pair_en_i);
  c_xch_acc: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    xch_cmd == XCH_ACCFLAGS ##1 acc_wr_en_i);
  c_pair3: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_pair_en_i && wr_pair_sel_i == PAIR_3);
  c_prio_acc: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    acc_wr_en_i && wr_pair_en_i && wr_pair_sel_i == PAIR_AF);

endmodule // dual_bank_regfile

//--- verification/regfile_dp_model.sv
module regfile_dp_model (
  input wire logic clk_i,
  output logic be_o,
  output logic [2:0] bs_o,
  output logic [7:0] bd_o,
  output logic pe_o,
  output logic [1:0] ps_o,
  output logic [15:0] pd_o,
  output logic ae_o,
  output logic [7:0] ad_o,
  output logic fe_o,
  output logic [7:0] fd_o,
  output logic [1:0] x_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Datapath side: one request per cycle, set on the falling edge.
  // ****************************************************************
  initial begin
    {be_o, bs_o, bd_o, pe_o, ps_o, pd_o} = '0;
    {ae_o, ad_o, fe_o, fd_o, x_o} = '0;
  end
  task automatic op(input logic be, input logic [2:0] bs,
    input logic [7:0] bd, input logic pe, input logic [1:0] ps,
    input logic [15:0] pd, input logic ae, input logic [7:0] ad,
    input logic fe, input logic [7:0] fd, input logic [1:0] x);
    @(negedge clk_i);
    {be_o, bs_o, bd_o, pe_o, ps_o, pd_o} = {be, bs, bd, pe, ps, pd};
    {ae_o, ad_o, fe_o, fd_o} = {ae, ad, fe, fd};
    x_o = x;
  endtask
endmodule // regfile_dp_model

//--- verification/dual_bank_cpu_register_file_tb.sv
module dual_bank_cpu_register_file_tb;
  import regfile_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sa = '0;
  logic [2:0] sb = '0;
  logic [1:0] sp = '0;
  logic [7:0] ra, rb, acc, flg, bd, ad, fd;
  logic [15:0] rp, pd;
  logic be, pe, ae, fe, abk, pbk;
  logic [2:0] bs;
  logic [1:0] ps, x;
  logic [7:0] m [2][8];
  logic eab, epb;
  int miscompares = 0;
  int checks = 0;
  always #20 clk = ~clk;
  regfile_dp_model dp (.clk_i(clk), .be_o(be), .bs_o(bs), .bd_o(bd),
    .pe_o(pe), .ps_o(ps), .pd_o(pd), .ae_o(ae), .ad_o(ad), .fe_o(fe),
    .fd_o(fd), .x_o(x));
  dual_bank_regfile dut_u (.ref_clk_i(clk), .sys_rst_i(rst),
    .rd_a_sel_i(sa), .rd_a_data_o(ra), .rd_b_sel_i(sb), .rd_b_data_o(rb),
    .rd_pair_sel_i(sp), .rd_pair_data_o(rp), .acc_o(acc), .flags_o(flg),
    .wr_byte_en_i(be), .wr_byte_sel_i(bs), .wr_byte_data_i(bd),
    .wr_pair_en_i(pe), .wr_pair_sel_i(ps), .wr_pair_data_i(pd),
    .acc_wr_en_i(ae), .acc_result_i(ad), .flags_wr_en_i(fe),
    .flags_result_i(fd), .xch_i(x), .acc_bank_o(abk), .pair_bank_o(pbk));
  // ****************************************************************
  // Reference model and comparison.
  // ****************************************************************
  function automatic logic [7:0] eb(int i);
    return m[(i > 5) ? eab : epb][i];
  endfunction
  function automatic logic [15:0] ep(int p);
    return (p == 3) ? {eb(6), eb(7)} : {eb(2 * p), eb(2 * p + 1)};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic b, input logic [2:0] s, input logic [7:0] d,
    input logic p, input logic [1:0] q, input logic [15:0] e,
    input logic a, input logic [7:0] av, input logic f,
    input logic [7:0] fv, input logic [1:0] xc);
    dp.op(b, s, d, p, q, e, a, av, f, fv, xc);
    if (b) m[(s > 5) ? eab : epb][s] = d;
    if (p && q == 2'h3) {m[eab][6], m[eab][7]} = e;
    if (p && q != 2'h3) {m[epb][2 * q], m[epb][2 * q + 1]} = e;
    if (a) m[eab][7] = av;
    if (f) m[eab][6] = fv;
    if (xc == 2'h1) eab = ~eab;
    if (xc == 2'h2) epb = ~epb;
  endtask
  task automatic check_all();
    w(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      sa = 3'(i);
      sb = 3'(i ^ 1);
      sp = 2'(i / 2);
      #1;
      chk(ra, eb(i));
      chk(rb, eb(i ^ 1));
      chk(rp, ep(i / 2));
    end
    chk({acc, flg}, {eb(7), eb(6)});
    chk({abk, pbk}, {eab, epb});
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    m = '{default: 8'h00};
    eab = BANK_MAIN;
    epb = BANK_MAIN;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check_all();
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_bytes();
    sa = IDX_PAIR2_HI;
    for (int i = 0; i < 8; i++) w(1, 3'(i), 8'(8'h1F + i * 8'h23),
      0, 0, 0, 0, 0, 0, 0, 0);
    check_all();
  endtask
  task automatic t_pairs();
    for (int i = 0; i < 4; i++) w(0, 0, 0, 1, 2'(i),
      16'(16'hA1B2 + i * 16'h1357), 0, 0, 0, 0, 0);
    check_all();
  endtask
  task automatic t_xch();
    w(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2'h2);
    check_all();
    w(1, IDX_PAIR3_DN, 8'h5A, 1, PAIR_1, 16'hC3D4, 0, 0, 0, 0, 2'h1);
    w(0, 0, 0, 0, 0, 0, 1, 8'h9E, 1, 8'h41, 2'h3);
    check_all();
    w(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2'h2);
    w(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2'h1);
    check_all();
  endtask
  task automatic t_prio();
    w(1, IDX_ACC, 8'h66, 0, 0, 0, 1, 8'h77, 1, 8'h88, 0);
    w(1, IDX_PAIR2_LO, 8'h12, 1, PAIR_2, 16'hBEEF, 0, 0, 0, 0, 0);
    w(1, IDX_FLAGS, 8'h34, 1, PAIR_AF, 16'h5678, 1, 8'hAB, 0, 0, 0);
    check_all();
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    do_reset();
    t_bytes();
    t_pairs();
    t_xch();
    t_prio();
    do_reset();
    t_pairs();
    stop_test();
  end
endmodule // dual_bank_cpu_register_file_tb
